// ### tdc_cfg_pkg.sv
// Package of constants and types for the converter configuration word.
package tdc_cfg_pkg;

	// ----------------------------------------
	// Bus map
	// ----------------------------------------
	localparam logic [7:0] CFG_OFFS    = 8'h00;
	localparam logic [7:0] STATUS_OFFS = 8'h04;
	localparam logic [7:0] CTRL_OFFS   = 8'h08;

	// ----------------------------------------
	// Field positions in the configuration word
	// ----------------------------------------
	localparam int ID_LSB        = 0;
	localparam int START_INV_BIT = 8;
	localparam int STOP1_INV_BIT = 9;
	localparam int STOP2_INV_BIT = 10;
	localparam int MODE2_BIT     = 11;
	localparam int NOCAL_BIT     = 12;
	localparam int CALIB_BIT     = 13;
	localparam int TCLK_SEL_BIT  = 14;
	localparam int DUMMY_BIT     = 15;
	localparam int TEMP_CYCLE_TIME_BIT    = 16;
	localparam int PORTS_BIT     = 17;
	localparam int SETTLE_LSB    = 18;
	localparam int HSDIV_LSB     = 20;
	localparam int CALPER_LSB    = 22;
	localparam int FDIV_LSB      = 24;
	localparam int FCNT_LSB      = 28;

	// ----------------------------------------
	// Reset value of the configuration word
	// ----------------------------------------
	localparam logic [31:0] CFG_RESET = 32'h2246_6800;

	// ----------------------------------------
	// Timing constants at the 40 MHz clock
	// ----------------------------------------
	localparam int CLK_NS      = 25;
	localparam int SETTLE_US   = 480;
	localparam int SETTLE_CYC  = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int TCYC_FAST   = 128;
	localparam int DUMMY_FEW   = 2;
	localparam int DUMMY_MANY  = 7;
	localparam int FIRE_MAX    = 127;

	// Decoded configuration fields.
	typedef struct packed {
		logic [3:0] fire_pulse_count;
		logic [3:0] fire_div;
		logic [1:0] resonator_cal_periods;
		logic [1:0] hs_clock_divider;
		logic [1:0] hs_osc_settle_select;
		logic       temp_port_count;
		logic       temp_cycle_time;
		logic       temp_dummy_cycles;
		logic       temp_cycle_clock_select;
		logic       calibrate;
		logic       no_cal_auto;
		logic       second_measure_mode;
		logic       stop2_invert;
		logic       stop1_invert;
		logic       start_invert;
		logic [7:0] user_id_byte0;
	} cfg_t;

endpackage

// ### tdc_measure_config.sv
// Configuration word of the time-to-digital converter with its steered logic.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tdc_measure_config (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Front-end inputs and oscillator request.
	input  wire logic        start_in,
	input  wire logic        stop1_in,
	input  wire logic        stop2_in,
	input  wire logic        osc_on,
	input  wire logic        temp_req,
	input  wire logic        measure_done,
	// Derived outputs.
	output logic             start_edge,
	output logic             stop1_edge,
	output logic             stop2_edge,
	output logic             hs_tick,
	output logic             fire_out,
	output logic             fire_busy,
	output logic             settled,
	output logic             temp_tick,
	output logic             dummy_phase,
	output logic             cal_run,
	output logic             mode2,
	output logic             calibrated,
	output logic [2:0]       temp_ports,
	output logic             temp_long_cycle
);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [31:0]             cfg_r;
	logic [6:0]              fire_ext_r;
	tdc_cfg_pkg::cfg_t       cfg;
	logic                    wr_cfg;
	logic                    wr_ctrl;

	assign cfg     = tdc_cfg_pkg::cfg_t'(cfg_r);
	assign wr_cfg  = psel && penable && pwrite &&
		(paddr == tdc_cfg_pkg::CFG_OFFS);
	assign wr_ctrl = psel && penable && pwrite &&
		(paddr == tdc_cfg_pkg::CTRL_OFFS);
	assign pready  = 1'b1;
	assign pslverr = psel && penable &&
		(paddr != tdc_cfg_pkg::CFG_OFFS) &&
		(paddr != tdc_cfg_pkg::STATUS_OFFS) &&
		(paddr != tdc_cfg_pkg::CTRL_OFFS);

	// Configuration changes only on a write to its word.
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_r <= tdc_cfg_pkg::CFG_RESET;
		end else if (wr_cfg) begin
			cfg_r <= pwdata;
		end
	end

	// Upper fire-count bits live in the control word.
	always_ff @(posedge clk) begin
		if (rst) begin
			fire_ext_r <= 7'h00;
		end else if (wr_ctrl) begin
			fire_ext_r <= pwdata[6:0];
		end
	end

	// Read data is registered in the setup cycle so it is ready at access.
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				tdc_cfg_pkg::CFG_OFFS:    prdata <= cfg_r;
				tdc_cfg_pkg::CTRL_OFFS:   prdata <= {25'h0, fire_ext_r};
				tdc_cfg_pkg::STATUS_OFFS: prdata <= {28'h0, dummy_phase,
					cal_run, fire_busy, settled};
				default:                  prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Mode outputs
	// ----------------------------------------
	assign mode2           = cfg.second_measure_mode;
	assign calibrated      = cfg.calibrate;
	assign temp_ports      = cfg.temp_port_count ? 3'h4 : 3'h2;
	assign temp_long_cycle = cfg.temp_cycle_time;

	// ----------------------------------------
	// Edge detection with optional inversion
	// ----------------------------------------
	logic [2:0] pin_r;
	logic [2:0] pin_now;

	assign pin_now = {stop2_in ^ cfg.stop2_invert,
		stop1_in ^ cfg.stop1_invert, start_in ^ cfg.start_invert};

	// Previous level after inversion.
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_r <= 3'h7;
		end else begin
			pin_r <= pin_now;
		end
	end

	// A rising edge of the possibly inverted signal is the active edge.
	always_ff @(posedge clk) begin
		if (rst) begin
			start_edge <= 1'b0;
			stop1_edge <= 1'b0;
			stop2_edge <= 1'b0;
		end else begin
			start_edge <= pin_now[0] && !pin_r[0];
			stop1_edge <= pin_now[1] && !pin_r[1];
			stop2_edge <= pin_now[2] && !pin_r[2];
		end
	end

	// ----------------------------------------
	// High-speed clock predivider
	// ----------------------------------------
	logic [1:0] hs_cnt_r;
	logic [1:0] hs_lim;

	assign hs_lim = (cfg.hs_clock_divider == 2'h0) ? 2'h0 :
		(cfg.hs_clock_divider == 2'h1) ? 2'h1 : 2'h3;

	// Tick once every divided period.
	always_ff @(posedge clk) begin
		if (rst) begin
			hs_cnt_r <= 2'h0;
			hs_tick  <= 1'b0;
		end else if (hs_cnt_r >= hs_lim) begin
			hs_cnt_r <= 2'h0;
			hs_tick  <= 1'b1;
		end else begin
			hs_cnt_r <= hs_cnt_r + 2'h1;
			hs_tick  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Oscillator settling wait
	// ----------------------------------------
	logic [16:0] settle_cnt_r;
	logic [1:0]  settle_mult;

	// Selections above the minimum scale the base wait (extension bit
	// is held outside this word).
	assign settle_mult = (cfg.hs_osc_settle_select == 2'h0) ? 2'h0 :
		cfg.hs_osc_settle_select - 2'h1;

	// Count from switch-on; code zero means the oscillator runs on.
	always_ff @(posedge clk) begin
		if (rst || !osc_on) begin
			settle_cnt_r <= 17'h0_0000;
			settled      <= 1'b0;
		end else if (cfg.hs_osc_settle_select == 2'h0) begin
			settled <= 1'b1;
		end else if (settle_cnt_r ==
			17'((tdc_cfg_pkg::SETTLE_CYC << settle_mult) - 1)) begin
			settled <= 1'b1;
		end else if (!settled) begin
			settle_cnt_r <= settle_cnt_r + 17'h0_0001;
		end
	end

	// ----------------------------------------
	// Fire pulse generator
	// ----------------------------------------
	logic [3:0] fdiv_cnt_r;
	logic [6:0] fire_left_r;
	logic [6:0] fire_total;

	assign fire_total = (fire_ext_r[2:0] != 3'h0) ?
		{fire_ext_r[2:0], cfg.fire_pulse_count} :
		{3'h0, cfg.fire_pulse_count};

	// Fire clock predivider by code plus one.
	always_ff @(posedge clk) begin
		if (rst || !fire_busy) begin
			fdiv_cnt_r <= 4'h0;
		end else if (fdiv_cnt_r == cfg.fire_div) begin
			fdiv_cnt_r <= 4'h0;
		end else begin
			fdiv_cnt_r <= fdiv_cnt_r + 4'h1;
		end
	end

	// Burst of exactly the programmed count, one pulse per divided period.
	always_ff @(posedge clk) begin
		if (rst) begin
			fire_left_r <= 7'h00;
			fire_busy   <= 1'b0;
			fire_out    <= 1'b0;
		end else if (!fire_busy) begin
			fire_out <= 1'b0;
			if (start_edge && settled && fire_total != 7'h00) begin
				fire_left_r <= fire_total;
				fire_busy   <= 1'b1;
			end
		end else if (fdiv_cnt_r == cfg.fire_div) begin
			fire_out    <= 1'b1;
			fire_left_r <= fire_left_r - 7'h01;
			fire_busy   <= (fire_left_r != 7'h01);
		end else begin
			fire_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Temperature cycle clock and dummy cycles
	// ----------------------------------------
	logic [6:0] tclk_cnt_r;
	logic [2:0] dummy_left_r;

	// Cycle tick every 128 high-speed ticks; held low when the slow clock is selected.
	always_ff @(posedge clk) begin
		if (rst) begin
			tclk_cnt_r <= 7'h00;
			temp_tick  <= 1'b0;
		end else if (!cfg.temp_cycle_clock_select) begin
			tclk_cnt_r <= 7'h00;
			temp_tick  <= 1'b0; // slow-clock domain outside
		end else if (hs_tick) begin
			tclk_cnt_r <= tclk_cnt_r + 7'h01;
			temp_tick  <= (tclk_cnt_r == 7'(tdc_cfg_pkg::TCYC_FAST - 1));
		end else begin
			temp_tick <= 1'b0;
		end
	end

	// Dummy measurements at the start of each temperature run.
	always_ff @(posedge clk) begin
		if (rst) begin
			dummy_left_r <= 3'h0;
			dummy_phase  <= 1'b0;
		end else if (temp_req && !dummy_phase) begin
			dummy_left_r <= cfg.temp_dummy_cycles ?
				3'(tdc_cfg_pkg::DUMMY_MANY) :
				3'(tdc_cfg_pkg::DUMMY_FEW);
			dummy_phase  <= 1'b1;
		end else if (dummy_phase && temp_tick) begin
			dummy_left_r <= dummy_left_r - 3'h1;
			dummy_phase  <= (dummy_left_r != 3'h1);
		end
	end

	// ----------------------------------------
	// Auto-calibration request
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_run <= 1'b0;
		end else begin
			cal_run <= measure_done && !cfg.no_cal_auto;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	cfg_hold_a: assert property (@(posedge clk) disable iff (rst)
		!wr_cfg |=> $stable(cfg_r))
		else $error("Configuration changed without a write.");

	cfg_load_a: assert property (@(posedge clk) disable iff (rst)
		wr_cfg |=> cfg_r == $past(pwdata))
		else $error("Configuration write not stored.");

	cal_run_a: assert property (@(posedge clk) disable iff (rst)
		measure_done |=> cal_run == !$past(cfg.no_cal_auto))
		else $error("Calibration run does not follow its disable bit.");

	start_edge_a: assert property (@(posedge clk) disable iff (rst)
		(!cfg.start_invert && $stable(cfg_r) && $rose(start_in))
		|=> start_edge)
		else $error("Rising start edge missed.");

	ports_a: assert property (@(posedge clk) disable iff (rst)
		temp_ports == (cfg.temp_port_count ? 3'h4 : 3'h2))
		else $error("Temperature port count wrong.");

	// A tick at divide-by-four with no rewrite for four cycles.
	sequence hs_div4_s;
		(cfg.hs_clock_divider[1] && hs_tick && !wr_cfg) ##1 !wr_cfg [*3];
	endsequence
	hs_div_a: assert property (@(posedge clk) disable iff (rst)
		hs_div4_s |=> hs_tick)
		else $error("Divide-by-four period wrong.");

	hs_gap_a: assert property (@(posedge clk) disable iff (rst)
		(cfg.hs_clock_divider[1] && hs_tick && !wr_cfg) |=> !hs_tick)
		else $error("Divide-by-four tick repeated too soon.");

	fire_zero_a: assert property (@(posedge clk) disable iff (rst)
		(!fire_busy && fire_total == 7'h00) |=> !fire_busy)
		else $error("Fire burst began with zero count.");

	settle_min_a: assert property (@(posedge clk) disable iff (rst)
		$rose(settled) && cfg.hs_osc_settle_select != 2'h0
		|-> settle_cnt_r >= 17'(tdc_cfg_pkg::SETTLE_CYC - 1))
		else $error("Settling wait ended early.");

	dummy_load_a: assert property (@(posedge clk) disable iff (rst)
		$rose(dummy_phase) |-> dummy_left_r ==
		($past(cfg.temp_dummy_cycles) ? 3'h7 : 3'h2))
		else $error("Dummy count wrong.");

endmodule // tdc_measure_config

// ### tdc_host_model.sv
// Host model that programs the converter configuration over APB.
`timescale 1ns/1ps
module tdc_host_model (
	// Clock.
	input  wire logic        clk,
	// APB master side.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rdata;
	logic        rerr;

	// -------------------------------------------------------
	// Bus idle at time zero.
	// -------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// One transfer; waits for pready and takes the answer at that edge.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines show a changed pattern, never the old value.
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	// Configuration write as a careful host issues it.
	task automatic cfg_write(input logic [31:0] d);
		logic [31:0] v;
		v = d;
		// Calibration may only be off in the first measurement mode.
		if (v[tdc_cfg_pkg::MODE2_BIT])
			v[tdc_cfg_pkg::CALIB_BIT] = 1'b1;
		// The longest code needs the extension bit, kept elsewhere.
		if (v[tdc_cfg_pkg::SETTLE_LSB + 1] && v[tdc_cfg_pkg::SETTLE_LSB])
			v[tdc_cfg_pkg::SETTLE_LSB] = 1'b0;
		xfer(1'b1, tdc_cfg_pkg::CFG_OFFS, v);
	endtask
endmodule // tdc_host_model

// ### test_tdc_measure_config.sv
// Self-checking bench for the converter configuration block.
`timescale 1ns/1ps
module test_tdc_measure_config;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic start_in, stop1_in, stop2_in, osc_on, temp_req, measure_done;
	logic start_edge, stop1_edge, stop2_edge, hs_tick, fire_out;
	logic fire_busy, settled, temp_tick, dummy_phase, cal_run, mode2;
	logic calibrated, temp_long_cycle;
	logic [2:0] temp_ports;
	int fails, checks_done, n_st, n_s1, n_s2, n_hs, n_fi, n_tt, n_cr;
	int a, b, c, n;
	logic [31:0] row_w [3] = '{32'h0000_0000, 32'h0003_28A5, 32'h0001_205A};
	logic [5:0] row_e [3] = '{6'h02, 6'h3C, 6'h1A};

	tdc_measure_config uut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.start_in(start_in), .stop1_in(stop1_in), .stop2_in(stop2_in),
		.osc_on(osc_on), .temp_req(temp_req), .measure_done(measure_done),
		.start_edge(start_edge), .stop1_edge(stop1_edge),
		.stop2_edge(stop2_edge), .hs_tick(hs_tick), .fire_out(fire_out),
		.fire_busy(fire_busy), .settled(settled), .temp_tick(temp_tick),
		.dummy_phase(dummy_phase), .cal_run(cal_run), .mode2(mode2),
		.calibrated(calibrated), .temp_ports(temp_ports),
		.temp_long_cycle(temp_long_cycle));
	tdc_host_model host (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ------------------------------------------------------
	// Clock, pulse counters and helpers.
	// ------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Counts every pulse output so tests compare differences.
	always @(posedge clk) begin
		if (start_edge === 1'b1) n_st <= n_st + 1;
		if (stop1_edge === 1'b1) n_s1 <= n_s1 + 1;
		if (stop2_edge === 1'b1) n_s2 <= n_s2 + 1;
		if (hs_tick === 1'b1) n_hs <= n_hs + 1;
		if (fire_out === 1'b1) n_fi <= n_fi + 1;
		if (temp_tick === 1'b1) n_tt <= n_tt + 1;
		if (cal_run === 1'b1) n_cr <= n_cr + 1;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic close_out();
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog against a hung wait.
	initial begin
		#(60000 * 25);
		fails++;
		close_out();
	end

	// ------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------
	initial begin
		{rst, start_in, stop1_in, stop2_in, temp_req, measure_done} = 6'h20;
		osc_on = 1'b1;
		{fails, checks_done, n_st, n_s1, n_s2, n_hs} = '0;
		{n_fi, n_tt, n_cr} = '0;
		cyc(16);
		rst <= 1'b0;
		host.xfer(1'b0, tdc_cfg_pkg::CFG_OFFS, 32'h0);
		chk("cfg_reset", tdc_cfg_pkg::CFG_RESET, host.rdata);
		for (int i = 0; i < 3; i++) begin
			host.cfg_write(row_w[i]);
			cyc(2);
			chk("levels", 32'(row_e[i]), {mode2, calibrated,
				temp_long_cycle, temp_ports});
			host.xfer(1'b0, tdc_cfg_pkg::CFG_OFFS, 32'h0);
			chk("readback", row_w[i], host.rdata);
		end
		// Unmapped place is refused and leaves the word alone.
		host.xfer(1'b1, 8'h0C, 32'hFFFF_FFFF);
		chk("slverr", 32'h1, 32'(host.rerr));
		host.xfer(1'b0, 8'h0C, 32'h0);
		chk("unmapped_rd", 32'h0, host.rdata);
		host.xfer(1'b0, tdc_cfg_pkg::CFG_OFFS, 32'h0);
		chk("kept", row_w[2], host.rdata);
		// Edge polarity for all three front-end inputs.
		for (int inv = 0; inv < 2; inv++) begin
			host.cfg_write(32'h0000_2000 | (inv ? 32'h0000_0700 : 32'h0));
			{start_in, stop1_in, stop2_in} <= {3{inv[0]}};
			cyc(6);
			{a, b, c} = {n_st, n_s1, n_s2};
			{start_in, stop1_in, stop2_in} <= {3{~inv[0]}};
			cyc(6);
			chk("edges_act", 32'h7, {n_st - a == 1, n_s1 - b == 1,
				n_s2 - c == 1});
			{a, b, c} = {n_st, n_s1, n_s2};
			{start_in, stop1_in, stop2_in} <= {3{inv[0]}};
			cyc(6);
			chk("edges_idle", 32'h0, n_st + n_s1 + n_s2 - a - b - c);
		end
		// Pins back low so the fire test sees a fresh start edge.
		{start_in, stop1_in, stop2_in} <= 3'h0;
		// Predivider rates for every code.
		for (int k = 0; k < 4; k++) begin
			host.cfg_write(32'h0000_2000 | (k << tdc_cfg_pkg::HSDIV_LSB));
			cyc(4);
			a = n_hs;
			cyc(16);
			chk("hs_ticks", k == 0 ? 16 : k == 1 ? 8 : 4, n_hs - a);
		end
		// Cycle clock from the fast clock, then from the slow source.
		for (int k = 1; k >= 0; k--) begin
			host.cfg_write(32'h0000_2000 | (k << tdc_cfg_pkg::TCLK_SEL_BIT));
			cyc(4);
			a = n_tt;
			cyc(512);
			chk("temp_ticks", 4 * k, n_tt - a);
		end
		// Auto-calibration on, then disabled.
		for (int k = 0; k < 2; k++) begin
			host.cfg_write(32'h0000_2000 | (k << tdc_cfg_pkg::NOCAL_BIT));
			a = n_cr;
			measure_done <= 1'b1;
			cyc(1);
			measure_done <= 1'b0;
			cyc(8);
			chk("cal_runs", 1 - k, n_cr - a);
		end
		// Dummy phase starts a temperature run.
		temp_req <= 1'b1;
		cyc(1);
		temp_req <= 1'b0;
		n = 0;
		repeat (8) begin
			@(posedge clk);
			n += (dummy_phase === 1'b1);
		end
		chk("dummy_seen", 32'h1, 32'(n > 0));
		// Fire bursts: 3 slow pulses, none, then the full 127.
		host.cfg_write(32'h3F00_2000);
		a = n_fi;
		start_in <= 1'b1;
		cyc(24);
		chk("fire_div", 32'h1, n_fi - a);
		start_in <= 1'b0;
		cyc(60);
		chk("fire_three", 32'h3, n_fi - a);
		host.cfg_write(32'h0F00_2000);
		a = n_fi;
		start_in <= 1'b1;
		cyc(40);
		start_in <= 1'b0;
		chk("fire_zero", 32'h0, n_fi - a);
		host.xfer(1'b1, tdc_cfg_pkg::CTRL_OFFS, 32'h0000_0007);
		host.cfg_write(32'hF000_2000);
		a = n_fi;
		start_in <= 1'b1;
		cyc(400);
		start_in <= 1'b0;
		chk("fire_max", tdc_cfg_pkg::FIRE_MAX, n_fi - a);
		// Shortest settling wait after switch-on.
		osc_on <= 1'b0;
		host.cfg_write(32'h0004_2000);
		cyc(4);
		osc_on <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (settled !== 1'b1 && n < 25000);
		chk("settle", 32'h1, 32'(n >= tdc_cfg_pkg::SETTLE_CYC - 3
			&& n <= tdc_cfg_pkg::SETTLE_CYC + 3));
		// A second reset restores the default word.
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		host.xfer(1'b0, tdc_cfg_pkg::CFG_OFFS, 32'h0);
		chk("cfg_reset2", tdc_cfg_pkg::CFG_RESET, host.rdata);
		close_out();
	end
endmodule // test_tdc_measure_config
